// ===== design/cbp_pkg.sv
package cbp_pkg;

  localparam logic [31:0] CBP_PREAMBLE      = 32'hFFFFBDB3;
  localparam logic [31:0] CBP_ALL_ONES      = 32'hFFFFFFFF;
  localparam logic [7:0]  CBP_COMMENT_TERM  = 8'h00;
  localparam logic [15:0] CBP_CRC_POLY      = 16'h8005;
  localparam logic [15:0] CBP_SETUP_ADDR    = 16'h4000;
  localparam logic [15:0] CBP_SETUP_FRAMES  = 16'h0020;

  localparam logic [7:0]  CBP_OP_CRC_CLEAR  = 8'h3B;
  localparam logic [7:0]  CBP_OP_IDENTITY   = 8'hE2;
  localparam logic [7:0]  CBP_OP_CTL0       = 8'h22;
  localparam logic [7:0]  CBP_OP_CTL1       = 8'h23;
  localparam logic [7:0]  CBP_OP_FRAME_ADDR = 8'hB4;
  localparam logic [7:0]  CBP_OP_BURST      = 8'h82;

  localparam int          CBP_OPC_HI        = 31;
  localparam int          CBP_OPC_LO        = 24;
  localparam int          CBP_CMP_BIT       = 23;
  localparam int          CBP_AT_END_BIT    = 22;
  localparam int          CBP_DDEF_BIT      = 20;
  localparam int          CBP_DCNT_HI       = 19;
  localparam int          CBP_DCNT_LO       = 16;

  localparam logic [15:0] CBP_WORD_LAST     = 16'h0003;
  localparam logic [15:0] CBP_CRC_LAST      = 16'h0001;

  localparam logic [7:0]  CBP_REG_STATUS    = 8'h00;
  localparam logic [7:0]  CBP_REG_INT_CLEAR = 8'h04;
  localparam logic [7:0]  CBP_REG_INT_EN    = 8'h08;
  localparam logic [7:0]  CBP_REG_CTL0      = 8'h0C;
  localparam logic [7:0]  CBP_REG_CTL1      = 8'h10;
  localparam logic [7:0]  CBP_REG_INFO      = 8'h14;
  localparam logic [7:0]  CBP_REG_LOADER    = 8'h18;

  localparam int          CBP_EV_SYNC       = 0;
  localparam int          CBP_EV_FRAME      = 1;
  localparam int          CBP_EV_BURST      = 2;
  localparam int          CBP_EV_ERROR      = 3;

  localparam logic [1:0]  CBP_ERR_NONE      = 2'h0;
  localparam logic [1:0]  CBP_ERR_STREAM    = 2'h1;
  localparam logic [1:0]  CBP_ERR_IDENTITY  = 2'h2;
  localparam logic [1:0]  CBP_ERR_CRC       = 2'h3;

  localparam logic [3:0]  CBP_IEN_RESET     = 4'h0;
  localparam logic        CBP_ENABLE_RESET  = 1'b1;

  typedef enum logic [3:0] {
    CBP_ST_SIG, CBP_ST_COMMENT, CBP_ST_SYNC, CBP_ST_DUMMY, CBP_ST_CMD, CBP_ST_OPER,
    CBP_ST_CHECK, CBP_ST_FDATA, CBP_ST_FCRC, CBP_ST_FDUMMY, CBP_ST_ERROR
  } cbp_state_e;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } cbp_byte_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [7:0]  data;
    logic        last;
  } cbp_frame_byte_s;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        write;
    logic        read;
  } cbp_reg_req_s;

endpackage

// ===== design/cbp_loader.sv
`timescale 1ns/1ps
`default_nettype none
module cbp_loader
  import cbp_pkg::*;
#(
  parameter logic [31:0] SIGNATURE   = 32'h5A5A_0001, // arbitrary value
  parameter logic [31:0] DEVICE_ID   = 32'h1234_5678, // arbitrary value
  parameter int          FRAME_BYTES = 16
) (
  input  wire logic            clock,
  input  wire logic            reset,
  input  wire cbp_byte_s       stream_in,
  output logic                 stream_ready,
  output cbp_frame_byte_s      frame_out,
  input  wire cbp_reg_req_s    reg_req,
  output logic [31:0]          reg_rdata,
  output logic                 irq
);

  localparam logic [15:0] FRAME_LAST = 16'(FRAME_BYTES - 1);

  typedef struct packed {
    cbp_state_e      st;
    logic [15:0]     cnt;
    logic [31:0]     word;
    logic [15:0]     crc;
    logic            crc_on;
    logic [7:0]      op;
    logic            cmp;
    logic            at_end;
    logic [3:0]      dnum;
    logic [15:0]     fleft;
    logic [15:0]     faddr;
    logic [31:0]     ctl0;
    logic [31:0]     ctl1;
    logic [1:0]      err_cause;
    logic [3:0]      status;
    logic [3:0]      ien;
    logic            enable;
    logic [31:0]     rdata;
    cbp_frame_byte_s fout;
  } cbp_regs_s;

  cbp_regs_s q, d;

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[15] ^ b[i]) ? ({r[14:0], 1'b0} ^ CBP_CRC_POLY) : {r[14:0], 1'b0};
    end
    return r;
  endfunction

  function automatic logic [15:0] crc_word(input logic [15:0] c, input logic [31:0] w);
    logic [15:0] r;
    r = c;
    for (int i = 3; i >= 0; i--) begin
      r = crc_byte(r, w[i*8 +: 8]);
    end
    return r;
  endfunction

  function automatic logic [15:0] rev16(input logic [15:0] v);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      r[i] = v[15 - i];
    end
    return r;
  endfunction

  logic        take;
  logic [7:0]  b;
  logic [31:0] w;
  logic [3:0]  ev;

  assign take         = stream_in.valid && q.enable;
  assign b            = stream_in.data;
  assign w            = {q.word[23:0], b};
  assign stream_ready = q.enable;
  assign frame_out    = q.fout;
  assign reg_rdata    = q.rdata;
  assign irq          = |(q.status & q.ien);

  always_comb begin
    d = q;
    ev = '0;
    d.fout.valid = 1'b0;
    d.fout.last  = 1'b0;
    if (take) begin
      d.word = w;
      d.cnt  = q.cnt + 16'h0001;
      case (q.st)
        CBP_ST_SIG: begin
          if (q.cnt == CBP_WORD_LAST) begin
            d.cnt = '0;
            if (w == SIGNATURE) begin
              d.st = CBP_ST_COMMENT;
            end else begin
              d.st = CBP_ST_ERROR;
              d.err_cause = CBP_ERR_STREAM;
              ev[CBP_EV_ERROR] = 1'b1;
            end
          end
        end
        CBP_ST_COMMENT: begin
          if (b == CBP_COMMENT_TERM) begin
            d.st = CBP_ST_SYNC;
            d.word = '0;
          end
        end
        CBP_ST_SYNC: begin
          if (w == CBP_PREAMBLE) begin
            d.st = CBP_ST_DUMMY;
            d.cnt = '0;
            ev[CBP_EV_SYNC] = 1'b1;
          end
        end
        CBP_ST_DUMMY: begin
          // all-ones fill is swallowed untouched and never accumulated
          if (q.cnt == CBP_WORD_LAST) begin
            d.st = CBP_ST_CMD;
            d.cnt = '0;
          end
        end
        CBP_ST_CMD: begin
          if (q.cnt == CBP_WORD_LAST) begin
            d.cnt = '0;
            d.op  = w[CBP_OPC_HI:CBP_OPC_LO];
            d.cmp = w[CBP_CMP_BIT];
            d.st  = CBP_ST_OPER;
            if (w == CBP_ALL_ONES) begin
              d.st = CBP_ST_CMD;
              // a skipped identity check must still open accumulation for the words behind it
              d.crc_on = 1'b1;
            end else if (w[CBP_OPC_HI:CBP_OPC_LO] == CBP_OP_CRC_CLEAR) begin
              d.crc = '0;
              d.st  = CBP_ST_DUMMY;
            end else if (w[CBP_OPC_HI:CBP_OPC_LO] == CBP_OP_IDENTITY) begin
              d.crc_on = 1'b1;
              d.crc    = crc_word(q.crc, w);
            end else if (w[CBP_OPC_HI:CBP_OPC_LO] == CBP_OP_CTL0 ||
                         w[CBP_OPC_HI:CBP_OPC_LO] == CBP_OP_CTL1) begin
              d.crc = q.crc_on ? crc_word(q.crc, w) : q.crc;
            end else if (w[CBP_OPC_HI:CBP_OPC_LO] == CBP_OP_FRAME_ADDR) begin
              d.crc    = q.crc_on ? crc_word(q.crc, w) : q.crc;
              d.at_end = w[CBP_AT_END_BIT];
            end else if (w[CBP_OPC_HI:CBP_OPC_LO] == CBP_OP_BURST) begin
              d.crc    = q.crc_on ? crc_word(q.crc, w) : q.crc;
              d.at_end = w[CBP_AT_END_BIT];
              d.dnum   = w[CBP_DDEF_BIT] ? w[CBP_DCNT_HI:CBP_DCNT_LO] : 4'h0;
              d.fleft  = w[15:0];
              d.st     = (w[15:0] == 16'h0000) ? CBP_ST_CMD : CBP_ST_FDATA;
            end else begin
              // commands beyond the setup head are not decoded here
              d.st = CBP_ST_ERROR;
              d.err_cause = CBP_ERR_STREAM;
              ev[CBP_EV_ERROR] = 1'b1;
            end
          end
        end
        CBP_ST_OPER: begin
          d.crc = q.crc_on ? crc_byte(q.crc, b) : q.crc;
          if (q.cnt == CBP_WORD_LAST) begin
            d.cnt = '0;
            d.st  = q.cmp ? CBP_ST_CHECK : CBP_ST_CMD;
            if (q.op == CBP_OP_IDENTITY && w != DEVICE_ID) begin
              d.st = CBP_ST_ERROR;
              d.err_cause = CBP_ERR_IDENTITY;
              ev[CBP_EV_ERROR] = 1'b1;
            end else if (q.op == CBP_OP_CTL0) begin
              d.ctl0 = w;
            end else if (q.op == CBP_OP_CTL1) begin
              d.ctl1 = w;
            end else if (q.op == CBP_OP_FRAME_ADDR) begin
              d.faddr = w[15:0];
            end
          end
        end
        CBP_ST_CHECK: begin
          if (q.cnt == CBP_CRC_LAST) begin
            d.cnt = '0;
            d.st  = CBP_ST_CMD;
            if (q.crc != rev16(w[15:0])) begin
              d.st = CBP_ST_ERROR;
              d.err_cause = CBP_ERR_CRC;
              ev[CBP_EV_ERROR] = 1'b1;
            end
          end
        end
        CBP_ST_FDATA: begin
          d.crc = crc_byte(q.crc, b);
          d.fout.valid = 1'b1;
          d.fout.addr  = q.faddr;
          d.fout.data  = b;
          d.fout.last  = (q.cnt == FRAME_LAST);
          if (q.cnt == FRAME_LAST) begin
            d.cnt = '0;
            d.st  = CBP_ST_FCRC;
            ev[CBP_EV_FRAME] = 1'b1;
          end
        end
        CBP_ST_FCRC: begin
          if (q.cnt == CBP_CRC_LAST) begin
            d.cnt   = '0;
            d.fleft = q.fleft - 16'h0001;
            d.faddr = q.faddr + 16'h0001;
            d.st    = (q.dnum != 4'h0) ? CBP_ST_FDUMMY :
                      (q.fleft == 16'h0001) ? CBP_ST_CMD : CBP_ST_FDATA;
            if (q.fleft == 16'h0001 && q.dnum == 4'h0) begin
              ev[CBP_EV_BURST] = 1'b1;
            end
            // with compare-at-end set only the final frame is checked
            if (q.cmp && (!q.at_end || q.fleft == 16'h0001) &&
                q.crc != rev16(w[15:0])) begin
              d.st = CBP_ST_ERROR;
              d.err_cause = CBP_ERR_CRC;
              ev = '0;
              ev[CBP_EV_ERROR] = 1'b1;
            end
          end
        end
        CBP_ST_FDUMMY: begin
          // first pad byte restarts the crc unless compare-at-end is set, and is itself accumulated
          d.crc = crc_byte((q.cnt == 16'h0000 && !q.at_end) ? 16'h0000 : q.crc, b);
          if (q.cnt == 16'({12'h000, q.dnum} - 16'h0001)) begin
            d.cnt = '0;
            d.st  = (q.fleft == 16'h0000) ? CBP_ST_CMD : CBP_ST_FDATA;
            ev[CBP_EV_BURST] = (q.fleft == 16'h0000);
          end
        end
        default: begin
          // stuck until reset: a rejected stream must not load any further frames
          d.st  = CBP_ST_ERROR;
          d.cnt = q.cnt;
        end
      endcase
    end

    d.rdata = '0;
    if (reg_req.write) begin
      if (reg_req.addr == CBP_REG_INT_CLEAR) begin
        d.status = q.status & ~reg_req.wdata[3:0];
      end else if (reg_req.addr == CBP_REG_INT_EN) begin
        d.ien = reg_req.wdata[3:0];
      end else if (reg_req.addr == CBP_REG_LOADER) begin
        d.enable = reg_req.wdata[0];
      end
    end else if (reg_req.read) begin
      if (reg_req.addr == CBP_REG_STATUS) begin
        d.rdata = {28'h0000000, q.status};
      end else if (reg_req.addr == CBP_REG_INT_EN) begin
        d.rdata = {28'h0000000, q.ien};
      end else if (reg_req.addr == CBP_REG_CTL0) begin
        d.rdata = q.ctl0;
      end else if (reg_req.addr == CBP_REG_CTL1) begin
        d.rdata = q.ctl1;
      end else if (reg_req.addr == CBP_REG_INFO) begin
        d.rdata = {q.faddr, q.err_cause, q.crc_on, q.cmp, q.at_end, 7'h00, q.st};
      end else if (reg_req.addr == CBP_REG_LOADER) begin
        d.rdata = {31'h00000000, q.enable};
      end
    end
    // a new event wins over a clear in the same cycle
    d.status = d.status | ev;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      q           <= '0;
      q.st        <= CBP_ST_SIG;
      q.err_cause <= CBP_ERR_NONE;
      q.ien       <= CBP_IEN_RESET;
      q.enable    <= CBP_ENABLE_RESET;
    end else begin
      q <= d;
    end
  end

endmodule
`default_nettype wire

// ===== tb/cbp_loader_chk.sv
`timescale 1ns/1ps
`default_nettype none
module cbp_loader_chk
  import cbp_pkg::*;
#(
  parameter int FRAME_BYTES = 16
) (
  input wire logic            clock,
  input wire logic            reset,
  input wire cbp_byte_s       stream_in,
  input wire logic            stream_ready,
  input wire cbp_frame_byte_s frame_out,
  input wire cbp_reg_req_s    reg_req,
  input wire logic [31:0]     reg_rdata,
  input wire logic            irq
);
  logic [7:0]  nb_q;
  logic [15:0] fc_q;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // byte count saturates: only the first few dozen bytes matter here
  always_ff @(posedge clock) begin
    if (reset) begin
      nb_q <= '0;
      fc_q <= '0;
    end else begin
      if (stream_in.valid && stream_ready && nb_q != 8'hFF)
        nb_q <= nb_q + 8'h01;
      if (frame_out.valid)
        fc_q <= frame_out.last ? 16'h0000 : fc_q + 16'h0001;
    end
  end
  a_byte_cause: assert property (frame_out.valid |-> $past(stream_in.valid && stream_ready))
    else $error("frame byte without a taken stream byte");
  a_setup_addr: assert property (frame_out.valid |-> (frame_out.addr - CBP_SETUP_ADDR) < CBP_SETUP_FRAMES)
    else $error("frame byte outside the setup block");
  a_frame_len: assert property (frame_out.last |-> frame_out.valid && fc_q == FRAME_BYTES - 1)
    else $error("frame length wrong");
  a_crc_gap: assert property (frame_out.last |=> (!frame_out.valid) [*3])
    else $error("no room for check value and pad");
  a_sync_first: assert property (frame_out.valid |-> nb_q > 8'h11)
    else $error("frame data before header");
  a_irq_sticky: assert property (irq && !reg_req.write |=> irq)
    else $error("interrupt dropped without a write");
  a_irq_cause: assert property ($rose(irq) |-> $past((stream_in.valid && stream_ready) || reg_req.write))
    else $error("interrupt rose without cause");
  a_rdata_slot: assert property (!$past(reg_req.read) |-> reg_rdata == '0)
    else $error("read data outside its slot");
  cover property (frame_out.last);
  cover property ($rose(irq));
  cover property (reg_req.read ##1 reg_rdata != '0);
endmodule
bind cbp_loader cbp_loader_chk #(.FRAME_BYTES(FRAME_BYTES)) chk_u (
  .clock(clock), .reset(reset), .stream_in(stream_in), .stream_ready(stream_ready),
  .frame_out(frame_out), .reg_req(reg_req), .reg_rdata(reg_rdata), .irq(irq));
`default_nettype wire

// ===== tb/cbp_src.sv
`timescale 1ns/1ps
`default_nettype none
module cbp_src
  import cbp_pkg::*;
(
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic slow,
  input  wire logic ready,
  output var cbp_byte_s s
);
  logic [7:0] q[$];
  // a byte stands until taken; an idle data line toggles so a stale byte never looks valid
  always @(posedge clock) begin
    if (reset)
      s <= '0;
    else if (!s.valid || ready) begin
      if (s.valid)
        void'(q.pop_front());
      if (q.size() != 0 && !(slow && $urandom_range(1) == 0)) begin
        s.valid <= 1'b1;
        s.data <= q[0];
      end else begin
        s.valid <= 1'b0;
        s.data <= ~s.data;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/cbp_loader_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module cbp_loader_tb_top
  import cbp_pkg::*;
;
  localparam logic [31:0] SIG = 32'h5A5A0001; // arbitrary value
  localparam logic [31:0] ID = 32'h13572468; // arbitrary value
  localparam int FB = 4;
  localparam logic [31:0] STAT [4] = '{32'h7, 32'h9, 32'hB, 32'h7};
  localparam logic [1:0] CAUSE [4] = '{2'h0, 2'h2, 2'h3, 2'h0};
  logic            clock;
  logic            reset;
  logic            slow;
  cbp_byte_s       stream_in;
  logic            stream_ready;
  cbp_frame_byte_s frame_out;
  cbp_reg_req_s    reg_req;
  logic [31:0]     reg_rdata;
  logic            irq;
  logic [31:0]     rv;
  logic [15:0]     crc;
  logic [24:0]     eq[$];
  int              n_mismatch = 0;
  int              n_tests = 0;
  int              cyc = 0;
  cbp_loader #(.SIGNATURE(SIG), .DEVICE_ID(ID), .FRAME_BYTES(FB)) dut_u (
    .clock(clock), .reset(reset), .stream_in(stream_in), .stream_ready(stream_ready),
    .frame_out(frame_out), .reg_req(reg_req), .reg_rdata(reg_rdata), .irq(irq));
  cbp_src src_u (.clock(clock), .reset(reset), .slow(slow), .ready(stream_ready), .s(stream_in));
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    reg_req.write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clock);
    reg_req.read <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  function automatic logic [15:0] cs(input logic [15:0] c, input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? CBP_CRC_POLY : 16'h0000);
    return c;
  endfunction
  task automatic pb(input logic [7:0] b, input bit inc);
    src_u.q.push_back(b);
    if (inc)
      crc = cs(crc, b);
  endtask
  task automatic pw(input logic [31:0] w, input bit inc);
    for (int i = 3; i >= 0; i--)
      pb(w[8*i +: 8], inc);
  endtask
  task automatic rst();
    @(posedge clock);
    reset <= 1'b1;
    eq.delete();
    src_u.q.delete();
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    wr(CBP_REG_STATUS, 32'hF);
    rd(CBP_REG_STATUS);
    chk(rv, 32'h0);
    rd(CBP_REG_INT_EN);
    chk(rv, 32'h0);
    rd(8'h1C);
    chk(rv, 32'h0);
    rd(CBP_REG_LOADER);
    chk(rv, 32'(CBP_ENABLE_RESET));
    wr(CBP_REG_LOADER, 32'h0);
    #1 chk(stream_ready, 1'b0);
    wr(CBP_REG_LOADER, 32'h1);
    rd(CBP_REG_LOADER);
    chk(rv, 32'h1);
  endtask
  // mode 0 clean load, 1 wrong identity, 2 identity skipped and bad check value on frame 2,
  // 3 checked control word and compare at end, so inner frame check values are ignored
  task automatic run(input int mode);
    logic [31:0] c0;
    logic [31:0] c1;
    logic [15:0] r;
    logic [7:0]  d;
    c0 = $urandom;
    c1 = $urandom;
    slow <= mode != 0;
    pw(SIG, 0);
    pb(8'h41, 0);
    pb(CBP_COMMENT_TERM, 0);
    pb(8'h5C, 0);
    pw(CBP_PREAMBLE, 0);
    pw(CBP_ALL_ONES, 0);
    pw(32'h3B000000, 0);
    pw(CBP_ALL_ONES, 0);
    crc = 16'h0000;
    if (mode == 2) begin
      pw(CBP_ALL_ONES, 0);
    end else begin
      pw(32'hE2000000, 1);
      pw(mode == 1 ? ~ID : ID, 1);
    end
    pw(mode == 3 ? 32'h22800000 : 32'h22000000, 1);
    pw(c0, 1);
    if (mode == 3) begin
      r = {<<{crc}};
      pb(r[15:8], 0);
      pb(r[7:0], 0);
    end
    pw(32'h23000000, 1);
    pw(c1, 1);
    pw(32'hB4000000, 1);
    pw({16'h0000, CBP_SETUP_ADDR}, 1);
    pw({8'h82, ((mode == 3) ? 8'hD1 : 8'h91), CBP_SETUP_FRAMES}, 1);
    for (int f = 0; f < 32; f++) begin
      for (int k = 0; k < FB; k++) begin
        d = $urandom;
        pb(d, 1);
        if (mode == 0 || mode == 3 || (mode == 2 && f < 3))
          eq.push_back({CBP_SETUP_ADDR + 16'(f), d, k == FB - 1});
      end
      r = {<<{crc}};
      if ((mode == 2 && f == 2) || (mode == 3 && f != 31))
        r = ~r;
      pb(r[15:8], 0);
      pb(r[7:0], 0);
      if (mode != 3)
        crc = 16'h0000;
      pb(8'hFF, 1);
    end
    while (src_u.q.size() != 0)
      @(posedge clock);
    repeat (4) @(posedge clock);
    chk(eq.size(), 32'h0);
    rd(CBP_REG_STATUS);
    chk(rv, STAT[mode]);
    rd(CBP_REG_INFO);
    chk(rv[15:14], CAUSE[mode]);
    rd(CBP_REG_CTL0);
    chk(rv, mode == 1 ? 32'h0 : c0);
    rd(CBP_REG_CTL1);
    chk(rv, mode == 1 ? 32'h0 : c1);
    chk(irq, 1'b0);
    wr(CBP_REG_INT_EN, 32'hF);
    #1 chk(irq, 1'b1);
    wr(CBP_REG_INT_CLEAR, 32'hF);
    #1 chk(irq, 1'b0);
    $display("test %0d done", mode);
  endtask
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // every frame byte is compared in the cycle it stands
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
    if (!reset && frame_out.valid)
      chk(frame_out, {1'b1, eq.pop_front()});
  end
  initial begin
    reset = 1'b1;
    slow = 1'b0;
    reg_req = '0;
    void'($urandom(32'h3A2D288F));
    for (int m = 0; m < 4; m++) begin
      rst();
      run(m);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
